/* tcu_pin_model.sv */
// Pin-side model: capture input levels and the wire level of every pin.
`timescale 1ns/1ns
module tcu_pin_model
(
   input  wire logic       clk_sys_i,
   input  wire logic [3:0] pin_out_i,
   input  wire logic [3:0] pin_oe_i,
   output logic      [3:0] pin_in_o,
   output logic            ext_clk_o
);
   logic [3:0] drive_ff = 4'h0;

   // A pin the timer drives shows the timer's level, otherwise the model's level.
   assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drive_ff);
   // The external count source is unused here, so it stays quiet.
   assign ext_clk_o = 1'b0;

   // Levels change just after an edge and hold three cycles so every edge is seen.
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge clk_sys_i);
      drive_ff[idx] <= lvl;
      repeat (3) @(posedge clk_sys_i);
   endtask : set_pin
endmodule : tcu_pin_model

/* tcu_pkg.sv */
// Constants, register map and field layout of the capture/compare timer.
// How it works
// (RULE_01) Reserved pin-control bits 7 and 3 read one.
// (RULE_02) Register D compares at 0, captures at 1.
// (RULE_03) D compare action: none, low, high, toggle.
// (RULE_04) D capture edge: rising, falling, both edges.
// (RULE_05) Register C compares at 0, captures at 1.
// (RULE_06) C compare action: none, low, high, toggle.
// (RULE_07) C capture edge: rising, falling, both edges.
// (RULE_08) Sixteen-bit counter, clock chosen by three bits.
// (RULE_09) Clear-on-match zeroes counter at match A.
// (RULE_10) Wrap from all ones sets overflow flag.
// (RULE_11) Overflow request only while its enable is set.
// (RULE_12) Software accesses the counter sixteen bits wide.
// (RULE_13) Counter resets to zero.
// (RULE_14) Compare equality sets the channel event flag.
// (RULE_15) Compare match requests interrupt when enabled.
// (RULE_16) Capture edge stores counter, sets event flag.
// (RULE_17) Capture requests interrupt when enabled.
// (RULE_18) Buffer bits pair C with A, D with B.
// (RULE_19) Buffered compare match copies buffer into primary.
// (RULE_20) Buffered capture moves old primary into buffer.
// (RULE_21) Software accesses general registers sixteen bits wide.
// (RULE_22) General registers reset to all ones.
// (RULE_23) Pin-control A/B uses the same encodings.
// (RULE_24) Flag clears only by read-one, then write-zero.
// (RULE_25) Compare event fires on the tick leaving equality.
package tcu_pkg;

   // Register word addresses on the plain register port.
   localparam logic [3:0] ADDR_MODE     = 4'h0;
   localparam logic [3:0] ADDR_CTRL     = 4'h1;
   localparam logic [3:0] ADDR_IRQ_EN   = 4'h2;
   localparam logic [3:0] ADDR_STATUS   = 4'h3;
   localparam logic [3:0] ADDR_IO_AB    = 4'h4;
   localparam logic [3:0] ADDR_IO_CD    = 4'h5;
   localparam logic [3:0] ADDR_COUNT    = 4'h6;
   localparam logic [3:0] ADDR_GR_BASE  = 4'h8;

   // Field positions.
   localparam int MODE_START   = 0;
   localparam int MODE_BUF_A   = 2;
   localparam int MODE_BUF_B   = 3;
   localparam int CTRL_CKS_LO  = 4;
   localparam int CTRL_CLEAR   = 7;
   localparam int FLAG_OVF     = 7;
   localparam int IO_FSEL      = 2;
   localparam int IO_RSVD_LO   = 3;
   localparam int IO_RSVD_HI   = 7;

   // Reset values, counter top value and reserved-bit mask.
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] GR_RESET    = 16'hFFFF;
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam logic [7:0]  IO_RSVD_MASK = 8'h88;

   // Compare pin actions and capture edge codes.
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_LOW    = 2'h1;
   localparam logic [1:0] ACT_HIGH   = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] EDGE_RISE  = 2'h0;
   localparam logic [1:0] EDGE_FALL  = 2'h1;

   // Clock select: prescaler widths, codes 1xx pick the external clock.
   localparam logic [2:0] CKS_DIV1   = 3'h0;
   localparam logic [2:0] CKS_DIV2   = 3'h1;
   localparam logic [2:0] CKS_DIV4   = 3'h2;
   localparam logic [2:0] CKS_DIV8   = 3'h3;

endpackage : tcu_pkg

/* tcu_timer.sv */
// Capture/compare timer: counter, four general registers, flags and register port.
`timescale 1ns/1ns
module tcu_timer
   import tcu_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   output logic      [15:0] rd_data_o,
   input  wire logic        ext_clk_i,
   input  wire logic [3:0]  pin_in_i,
   output logic      [3:0]  pin_out_o,
   output logic      [3:0]  pin_oe_o,
   output logic             irq_o
);

   // Whole block state, registered as one word.
   typedef struct packed {
      logic [15:0]       count;
      logic [3:0][15:0]  gr;
      logic [7:0]        mode;
      logic [7:0]        ctrl;
      logic [7:0]        irq_en;
      logic [7:0]        io_ab;
      logic [7:0]        io_cd;
      logic [3:0]        imf;
      logic              ovf;
      logic [4:0]        armed;
      logic [3:0]        pin_prev;
      logic [3:0]        pin_out;
      logic [2:0]        pre;
      logic              ext_prev;
      logic [15:0]       rdata;
   } tcu_state_s;

   tcu_state_s st_ff;
   tcu_state_s nxt_st;

   logic        tick;
   logic [3:0]  fsel;
   logic [3:0]  cmp_hit;
   logic [3:0]  cap_hit;
   logic [3:0]  rise;
   logic [3:0]  fall;
   logic [7:0]  nib [4];
   logic        clear_a;
   logic        buf_a;
   logic        buf_b;
   logic        wr_status;

   // Counter clock: internal prescaler taps or the external clock edge.
   // (RULE_08) clock source select
   always_comb
   begin
      case (st_ff.ctrl[CTRL_CKS_LO +: 3])
         CKS_DIV1: tick = 1'b1;
         CKS_DIV2: tick = st_ff.pre[0];
         CKS_DIV4: tick = &st_ff.pre[1:0];
         CKS_DIV8: tick = &st_ff.pre;
         default:  tick = ext_clk_i & ~st_ff.ext_prev;
      endcase
      tick = tick & st_ff.mode[MODE_START];
   end

   assign buf_a     = st_ff.mode[MODE_BUF_A];
   assign buf_b     = st_ff.mode[MODE_BUF_B];
   assign wr_status = wr_en_i && (addr_i == ADDR_STATUS);
   assign rise      = pin_in_i & ~st_ff.pin_prev;
   assign fall      = ~pin_in_i & st_ff.pin_prev;

   // Per-channel compare and capture detection; A/B share one control byte, C/D another.
   // A channel that serves as a buffer raises no events of its own, so its pin stays quiet.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_chan
         logic [1:0] fld;
         logic       en;
         // (RULE_23) shared encodings for A/B and C/D
         assign nib[gi] = (gi < 2) ? st_ff.io_ab : st_ff.io_cd;
         assign fsel[gi] = nib[gi][IO_FSEL + 4 * (gi % 2)];
         assign fld = nib[gi][4 * (gi % 2) +: 2];
         assign en = !((gi == 2 && buf_a) || (gi == 3 && buf_b));
         // (RULE_25) match fires on the tick that leaves equality
         assign cmp_hit[gi] = en && !fsel[gi] && tick && (st_ff.count == st_ff.gr[gi]);
         // (RULE_04) capture edge choice, likewise (RULE_07)
         assign cap_hit[gi] = en && fsel[gi] &&
                              (fld[1] ? (rise[gi] | fall[gi]) :
                               (fld == EDGE_FALL) ? fall[gi] : rise[gi]);
      end
   endgenerate

   // (RULE_09) periodic clear on match A
   assign clear_a = cmp_hit[0] && st_ff.ctrl[CTRL_CLEAR];

   // Next-state logic: software writes first, hardware events override them.
   always_comb
   begin
      logic [1:0] act;
      act = ACT_NONE;
      nxt_st = st_ff;
      nxt_st.pre = st_ff.pre + 3'h1;
      nxt_st.ext_prev = ext_clk_i;
      nxt_st.pin_prev = pin_in_i;

      // Software writes; narrow registers take the low byte.
      // (RULE_12) whole-word counter and general register writes
      if (wr_en_i)
      begin
         case (addr_i)
            ADDR_MODE:   nxt_st.mode = wr_data_i[7:0];
            ADDR_CTRL:   nxt_st.ctrl = wr_data_i[7:0];
            ADDR_IRQ_EN: nxt_st.irq_en = wr_data_i[7:0];
            ADDR_IO_AB:  nxt_st.io_ab = wr_data_i[7:0];
            ADDR_IO_CD:  nxt_st.io_cd = wr_data_i[7:0];
            ADDR_COUNT:  nxt_st.count = wr_data_i;
            4'h8:        nxt_st.gr[0] = wr_data_i;
            4'h9:        nxt_st.gr[1] = wr_data_i;
            4'hA:        nxt_st.gr[2] = wr_data_i;
            4'hB:        nxt_st.gr[3] = wr_data_i;
            default:     nxt_st.ctrl = st_ff.ctrl;
         endcase
      end

      // (RULE_24) clear only bits that were read as one
      if (wr_status)
      begin
         nxt_st.imf = st_ff.imf & ~(st_ff.armed[3:0] & ~wr_data_i[3:0]);
         nxt_st.ovf = st_ff.ovf & ~(st_ff.armed[4] & ~wr_data_i[FLAG_OVF]);
         nxt_st.armed = 5'h00;
      end
      else if (rd_en_i && addr_i == ADDR_STATUS)
      begin
         nxt_st.armed = {st_ff.ovf, st_ff.imf};
      end

      // Counter advance, clear and wrap; a match-A clear beats a same-cycle wrap, so no overflow is flagged.
      if (tick)
      begin
         if (clear_a)
            nxt_st.count = COUNT_RESET;
         else
            nxt_st.count = st_ff.count + 16'h0001;
         // (RULE_10) overflow on wrap
         if (!clear_a && st_ff.count == COUNT_MAX)
            nxt_st.ovf = 1'b1;
      end

      for (int i = 0; i < 4; i++)
      begin
         act = nib[i][4 * (i % 2) +: 2];
         // (RULE_03) compare pin action, likewise (RULE_06)
         if (cmp_hit[i])
         begin
            case (act)
               ACT_LOW:    nxt_st.pin_out[i] = 1'b0;
               ACT_HIGH:   nxt_st.pin_out[i] = 1'b1;
               ACT_TOGGLE: nxt_st.pin_out[i] = ~st_ff.pin_out[i];
               default:    nxt_st.pin_out[i] = st_ff.pin_out[i];
            endcase
         end
         // (RULE_14) event flag set, wins over clear; also (RULE_16)
         if (cmp_hit[i] || cap_hit[i])
            nxt_st.imf[i] = 1'b1;
         // (RULE_16) capture stores the counter
         if (cap_hit[i])
            nxt_st.gr[i] = st_ff.count;
      end

      // (RULE_18) C buffers A, D buffers B
      for (int i = 0; i < 2; i++)
      begin
         if ((i == 0) ? buf_a : buf_b)
         begin
            // (RULE_19) buffered compare reload
            if (cmp_hit[i])
               nxt_st.gr[i] = st_ff.gr[i + 2];
            // (RULE_20) old primary moves to buffer
            if (cap_hit[i])
               nxt_st.gr[i + 2] = st_ff.gr[i];
         end
      end

      // Read data, valid in the cycle after the strobe only.
      nxt_st.rdata = 16'h0000;
      if (rd_en_i)
      begin
         case (addr_i)
            ADDR_MODE:   nxt_st.rdata = {8'h00, st_ff.mode};
            ADDR_CTRL:   nxt_st.rdata = {8'h00, st_ff.ctrl};
            ADDR_IRQ_EN: nxt_st.rdata = {8'h00, st_ff.irq_en};
            ADDR_STATUS: nxt_st.rdata = {8'h00, st_ff.ovf, 3'h0, st_ff.imf};
            // (RULE_01) reserved bits read one
            ADDR_IO_AB:  nxt_st.rdata = {8'h00, st_ff.io_ab | IO_RSVD_MASK};
            ADDR_IO_CD:  nxt_st.rdata = {8'h00, st_ff.io_cd | IO_RSVD_MASK};
            ADDR_COUNT:  nxt_st.rdata = st_ff.count;
            4'h8:        nxt_st.rdata = st_ff.gr[0];
            4'h9:        nxt_st.rdata = st_ff.gr[1];
            4'hA:        nxt_st.rdata = st_ff.gr[2];
            4'hB:        nxt_st.rdata = st_ff.gr[3];
            default:     nxt_st.rdata = 16'h0000;
         endcase
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         st_ff <= '0;
         // (RULE_13) counter to zero
         st_ff.count <= COUNT_RESET;
         // (RULE_22) general registers to all ones
         st_ff.gr <= {4{GR_RESET}};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs; the pin is driven only while its channel compares.
   // (RULE_02) function select drives mode, likewise (RULE_05)
   assign rd_data_o = st_ff.rdata;
   assign pin_out_o = st_ff.pin_out;
   assign pin_oe_o  = ~fsel;
   // (RULE_11) overflow request gated by enable; also (RULE_15) and (RULE_17)
   assign irq_o = |(st_ff.imf & st_ff.irq_en[3:0]) | (st_ff.ovf & st_ff.irq_en[FLAG_OVF]);

   // Checks of the documented behaviour.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   chk_rsvd_read_one: assert property ( // RULE_01
      rd_en_i && addr_i == ADDR_IO_CD |=> rd_data_o[IO_RSVD_HI] && rd_data_o[IO_RSVD_LO])
      else $error("Reserved pin-control bits did not read one.");

   chk_match_sets_flag: assert property ( // RULE_14
      cmp_hit[1] |=> st_ff.imf[1])
      else $error("Compare match B did not set its flag.");

   chk_count_clear_a: assert property ( // RULE_09
      clear_a && !wr_en_i |=> st_ff.count == COUNT_RESET)
      else $error("Counter not cleared at match A.");

   chk_overflow_flag: assert property ( // RULE_10
      tick && st_ff.count == COUNT_MAX && !clear_a && !wr_status |=> st_ff.ovf)
      else $error("Overflow flag not set on wrap.");

   chk_pin_toggle_c: assert property ( // RULE_06
      cmp_hit[2] && st_ff.io_cd[1:0] == ACT_TOGGLE |=> pin_out_o[2] != $past(pin_out_o[2]))
      else $error("Pin C did not toggle at match.");

   chk_capture_load_d: assert property ( // RULE_16
      cap_hit[3] && !wr_en_i |=> st_ff.gr[3] == $past(st_ff.count))
      else $error("Capture D did not store the counter.");

   chk_buffer_copy_a: assert property ( // RULE_19
      cmp_hit[0] && buf_a && !wr_en_i |=> st_ff.gr[0] == $past(st_ff.gr[2]))
      else $error("Buffer C not copied into A at match.");

   chk_overflow_irq: assert property ( // RULE_11
      st_ff.ovf && st_ff.irq_en[FLAG_OVF] |-> irq_o)
      else $error("Enabled overflow raised no request.");

   chk_flag_holds: assert property ( // RULE_24
      st_ff.imf[0] && !wr_status |=> st_ff.imf[0] ##0 st_ff.imf[0])
      else $error("Event flag A cleared without a status write.");

   chk_unread_no_clear: assert property ( // RULE_24
      !st_ff.armed[0] && st_ff.imf[0] && wr_status |=> st_ff.imf[0])
      else $error("Event flag A cleared without being read first.");

   // A capture on C must hold the count of the edge cycle, not a later one.
   chk_capture_load_c: assert property ( // RULE_16
      cap_hit[2] && !wr_en_i |=> st_ff.gr[2] == $past(st_ff.count))
      else $error("Capture C did not store the counter.");

   // Capture events raise their flag one cycle after the edge.
   chk_capture_sets_flag: assert property ( // RULE_16
      cap_hit[3] |=> st_ff.imf[3])
      else $error("Capture D did not set its flag.");

   // Buffered capture must save the old primary before it is overwritten.
   chk_buffer_capture_a: assert property ( // RULE_20
      cap_hit[0] && buf_a && !wr_en_i |=>
         st_ff.gr[2] == $past(st_ff.gr[0]) && st_ff.gr[0] == $past(st_ff.count))
      else $error("Buffered capture A did not shift old value into C.");

   // Drive-low action on pin D.
   chk_pin_low_d: assert property ( // RULE_03
      cmp_hit[3] && st_ff.io_cd[5:4] == ACT_LOW |=> !pin_out_o[3])
      else $error("Pin D did not go low at match.");

   // Drive-high action on pin D.
   chk_pin_high_d: assert property ( // RULE_03
      cmp_hit[3] && st_ff.io_cd[5:4] == ACT_HIGH |=> pin_out_o[3])
      else $error("Pin D did not go high at match.");

   // The no-action code must leave the pin where it was.
   chk_pin_hold_d: assert property ( // RULE_03
      cmp_hit[3] && st_ff.io_cd[5:4] == ACT_NONE |=> $stable(pin_out_o[3]))
      else $error("Pin D moved although no action was selected.");

   // The pin is driven only while its register compares.
   chk_pin_oe_d: assert property ( // RULE_02
      pin_oe_o[3] == !st_ff.io_cd[IO_FSEL + 4])
      else $error("Pin D drive does not follow its function select.");

   // Equality without a counter tick must never count as a match.
   chk_no_tick_no_match: assert property ( // RULE_25
      !tick |-> cmp_hit == 4'h0)
      else $error("Compare event without a counter tick.");

   // A tick moves the counter up by exactly one, wrapping at the top.
   chk_count_advance: assert property ( // RULE_08
      tick && !clear_a && !wr_en_i |=> st_ff.count == $past(st_ff.count) + 16'h0001)
      else $error("Counter did not advance by one on a tick.");

   // A stopped counter holds its value, so software can read it at leisure.
   chk_count_stopped: assert property ( // RULE_08
      !st_ff.mode[MODE_START] && !wr_en_i |=> $stable(st_ff.count))
      else $error("Stopped counter changed.");

   // An enabled capture flag must reach the request line at once.
   chk_event_irq_c: assert property ( // RULE_17
      st_ff.imf[2] && st_ff.irq_en[2] |-> irq_o)
      else $error("Enabled event C raised no request.");

   // A buffer channel stays quiet; otherwise it would disturb the primary.
   chk_buffer_quiet_c: assert property ( // RULE_18
      buf_a |-> !cmp_hit[2] && !cap_hit[2])
      else $error("Buffer channel C raised its own event.");

   // The A/B control byte reads its reserved bits as one, too.
   chk_rsvd_read_ab: assert property ( // RULE_23
      rd_en_i && addr_i == ADDR_IO_AB |=> rd_data_o[IO_RSVD_HI] && rd_data_o[IO_RSVD_LO])
      else $error("Reserved A/B pin-control bits did not read one.");

   cov_match_clear: cover property (clear_a ##1 st_ff.count == COUNT_RESET);
   cov_buffer_copy: cover property (cmp_hit[0] && buf_a);
   cov_capture_both: cover property (cap_hit[0] && buf_a);
   cov_overflow_irq: cover property ($rose(st_ff.ovf) ##1 irq_o);

endmodule : tcu_timer

/* testbench.sv */
// Self-checking bench for the capture/compare timer.
`timescale 1ns/1ns
module testbench;
   import tcu_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [3:0]  addr_i    = 4'h0;
   logic [15:0] wr_data_i = 16'h0000;
   logic        wr_en_i   = 1'b0;
   logic        rd_en_i   = 1'b0;
   logic [15:0] rd_data_o;
   logic        ext_clk_i;
   logic [3:0]  pin_in_i;
   logic [3:0]  pin_out_o;
   logic [3:0]  pin_oe_o;
   logic        irq_o;
   int          miscompares  = 0;
   int          total_checks = 0;
   logic [15:0] v;
   logic [1:0]  acts [4] = '{ACT_HIGH, ACT_NONE, ACT_LOW, ACT_TOGGLE};
   logic        exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

   tcu_timer i_tcu_timer (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .ext_clk_i(ext_clk_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
      .pin_oe_o(pin_oe_o), .irq_o(irq_o));
   tcu_pin_model i_tcu_pin_model (.clk_sys_i(clk_sys_i), .pin_out_i(pin_out_o),
      .pin_oe_i(pin_oe_o), .pin_in_o(pin_in_i), .ext_clk_o(ext_clk_i));

   // A 100 ns system clock.
   initial
   begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   // Software always moves whole 16-bit words; strobes last one cycle.
   // whole-word counter access, whole-word general registers
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_en_i   <= 1'b1;
      @(posedge clk_sys_i);
      wr_en_i   <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample mid-cycle.
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_sys_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_en_i <= 1'b0;
      @(negedge clk_sys_i);
      d = rd_data_o;
   endtask : rd

   task automatic rc(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rc

   // Poll the status register with a bound; a flag that never comes ends the run.
   task automatic wait_flag(input int idx);
      int n = 0;
      v = 16'h0000;
      while (v[idx] !== 1'b1 && n < 40)
      begin
         rd(ADDR_STATUS, v);
         n++;
      end
      if (v[idx] !== 1'b1)
      begin
         miscompares++;
         summarize();
      end
   endtask : wait_flag

   // Watchdog against a hang anywhere in the sequence.
   initial
   begin
      repeat (100000) @(posedge clk_sys_i);
      miscompares++;
      summarize();
   end

   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      // Reset values, reserved pin-control bits and an unmapped address.
      rc(ADDR_COUNT, COUNT_RESET);
      for (int i = 0; i < 4; i++)
         rc(ADDR_GR_BASE + 4'(i), GR_RESET);
      rc(ADDR_IO_CD, 16'h0088);
      wr(ADDR_IO_CD, 16'h0000);
      rc(ADDR_IO_CD, 16'h0088);
      rc(4'h7, 16'h0000);
      // Captures with the counter stopped, so the stored figure is exact.
      wr(ADDR_IO_CD, 16'h0054);
      wr(ADDR_IRQ_EN, 16'h0004);
      wr(ADDR_COUNT, 16'h1234);
      i_tcu_pin_model.set_pin(2, 1'b1);
      i_tcu_pin_model.set_pin(3, 1'b1);
      rc(4'hA, 16'h1234);
      rc(4'hB, 16'hFFFF);
      check({15'h0, irq_o}, 16'h0001);
      wr(ADDR_COUNT, 16'h2345);
      i_tcu_pin_model.set_pin(3, 1'b0);
      rc(4'hB, 16'h2345);
      wr(ADDR_IO_CD, 16'h0006);
      wr(ADDR_COUNT, 16'h0055);
      i_tcu_pin_model.set_pin(2, 1'b0);
      rc(4'hA, 16'h0055);
      // A write of zero without a prior read of one leaves the flags set.
      wr(ADDR_STATUS, 16'h0000);
      rc(ADDR_STATUS, 16'h000C);
      wr(ADDR_STATUS, 16'h0000);
      rc(ADDR_STATUS, 16'h0000);
      check({15'h0, irq_o}, 16'h0000);
      // Every compare action on C and D; the pins start low after reset.
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_MODE, 16'h0000);
         wr(ADDR_IO_CD, {8'h00, 2'b00, acts[i], 2'b00, acts[i]});
         wr(4'hA, 16'h0102);
         wr(4'hB, 16'h0102);
         wr(ADDR_COUNT, 16'h0100);
         wr(ADDR_MODE, 16'h0001);
         wait_flag(3);
         check({14'h0, pin_oe_o[3:2]}, 16'h0003);
         check({14'h0, pin_out_o[3:2]}, {14'h0, {2{exps[i]}}});
         rc(ADDR_STATUS, 16'h000C);
         wr(ADDR_STATUS, 16'h0000);
      end
      // Equality alone, with no counter tick, raises no compare event.
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_COUNT, 16'h0102);
      rc(ADDR_STATUS, 16'h0000);
      // Wrap from all ones; A and B match at all ones on the same tick.
      wr(ADDR_IRQ_EN, 16'h0000);
      wr(ADDR_COUNT, 16'hFFF0);
      wr(ADDR_MODE, 16'h0001);
      wait_flag(FLAG_OVF);
      wr(ADDR_MODE, 16'h0000);
      check({15'h0, irq_o}, 16'h0000);
      rc(ADDR_STATUS, 16'h0083);
      wr(ADDR_IRQ_EN, 16'h0080);
      // The counter ran a few ticks past the wrap before it was stopped.
      rd(ADDR_COUNT, v);
      check({15'h0, v < 16'h0010}, 16'h0001);
      check({15'h0, irq_o}, 16'h0001);
      wr(ADDR_STATUS, 16'h0000);
      // Periodic counting: the count never passes general register A.
      wr(ADDR_IO_AB, 16'h0000);
      wr(ADDR_GR_BASE, 16'h0005);
      wr(ADDR_COUNT, 16'h0000);
      wr(ADDR_CTRL, 16'h0080);
      wr(ADDR_MODE, 16'h0001);
      for (int i = 0; i < 8; i++)
      begin
         rd(ADDR_COUNT, v);
         check({15'h0, v <= 16'h0005}, 16'h0001);
      end
      wr(ADDR_MODE, 16'h0000);
      rd(ADDR_STATUS, v);
      wr(ADDR_STATUS, 16'h0000);
      // Buffered compare: match A reloads A from C.
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_GR_BASE, 16'h0020);
      wr(4'hA, 16'h0040);
      wr(ADDR_COUNT, 16'h001E);
      wr(ADDR_MODE, 16'h0005);
      wait_flag(0);
      wr(ADDR_MODE, 16'h0004);
      rc(ADDR_GR_BASE, 16'h0040);
      // Buffered capture: old A moves into C, the count into A.
      wr(ADDR_IO_AB, 16'h0004);
      wr(ADDR_COUNT, 16'h0777);
      i_tcu_pin_model.set_pin(0, 1'b1);
      rc(ADDR_GR_BASE, 16'h0777);
      rc(4'hA, 16'h0040);
      summarize();
   end
endmodule : testbench
